// File: psg_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the control registers
// Assumes: one write and one read outstanding at most
// Notes: write strobe pulses one cycle once address and data are both held
`timescale 1ns/1ns
`default_nettype none
module psg_axil_slave (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [psg_pkg::PSG_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [psg_pkg::PSG_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic regWrEn,
    output logic [psg_pkg::PSG_ADDR_W-1:0] regWrAddr,
    output logic [31:0] regWrData,
    output logic [3:0] regWrStrb,
    input wire logic regWrHit,
    input wire logic [31:0] regRdData,
    input wire logic regRdHit
);
    import psg_pkg::*;

    logic awFull_r;
    logic wFull_r;

    assign regWrEn = awFull_r && wFull_r && !bvalid;

    // address channel: held until the response is taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awFull_r <= 1'b0;
            awready <= 1'b1;
            regWrAddr <= '0;
        end else if (awvalid && awready) begin
            awFull_r <= 1'b1;
            awready <= 1'b0;
            regWrAddr <= awaddr;
        end else if (bvalid && bready) begin
            awFull_r <= 1'b0;
            awready <= 1'b1;
        end
    end

    // data channel, taken independently of the address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wFull_r <= 1'b0;
            wready <= 1'b1;
            regWrData <= '0;
            regWrStrb <= '0;
        end else if (wvalid && wready) begin
            wFull_r <= 1'b1;
            wready <= 1'b0;
            regWrData <= wdata;
            regWrStrb <= wstrb;
        end else if (bvalid && bready) begin
            wFull_r <= 1'b0;
            wready <= 1'b1;
        end
    end

    // write response one cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp <= PSG_RESP_OKAY;
        end else if (regWrEn) begin
            bvalid <= 1'b1;
            bresp <= regWrHit ? PSG_RESP_OKAY : PSG_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read: data captured at the address handshake
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= PSG_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= regRdHit ? regRdData : 32'h00000000;
            rresp <= regRdHit ? PSG_RESP_OKAY : PSG_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule : psg_axil_slave
`default_nettype wire

// File: psg_pkg.sv
// Purpose: constants for the shutdown/gate control block
// Assumes: 16-bit control register in the low half of a 32-bit word
// Notes: offsets are byte addresses on the register bus
package psg_pkg;
    // register byte offsets
    localparam logic [7:0] PSG_CTRL_OFS = 8'h00;
    localparam logic [7:0] PSG_STAT_OFS = 8'h04;
    localparam int PSG_ADDR_W = 8;
    // control register fields
    localparam int PSG_AUTO_RESTART_BIT = 15;
    localparam int PSG_SYNC_MODE_BIT = 14;
    localparam int PSG_SW_FORCE_BIT = 12;
    localparam int PSG_SRC_LSB = 0;
    localparam int PSG_SRC_W = 8;
    localparam logic [15:0] PSG_CTRL_RST = 16'h0000;
    localparam logic [15:0] PSG_CTRL_MASK = 16'hD0FF;
    // status register fields
    localparam int PSG_ST_SHUT_BIT = 0;
    localparam int PSG_ST_PEND_BIT = 1;
    localparam int PSG_ST_REQ_BIT = 2;
    localparam int PSG_ST_SRC_LSB = 8;
    // bus answers
    localparam logic [1:0] PSG_RESP_OKAY = 2'h0;
    localparam logic [1:0] PSG_RESP_SLVERR = 2'h2;
    // synchroniser depth
    localparam int PSG_SYNC_STAGES = 2;
    // shutdown sequencing states
    typedef enum logic [2:0] {
        PSG_RUN = 3'h1,
        PSG_PEND = 3'h2,
        PSG_SHUT = 3'h4
    } psg_state_t;
endpackage : psg_pkg

// File: psg_shutdown_gate_control.sv
// Purpose: auto-shutdown and gating control of a capture/compare/PWM unit
// Assumes: tbBoundary is a one-cycle pulse from the time base on clk
// Notes: sources are asynchronous and pass two flops before use
`timescale 1ns/1ns
`default_nettype none
module psg_shutdown_gate_control #(
    parameter int SRC_W = psg_pkg::PSG_SRC_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [psg_pkg::PSG_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [psg_pkg::PSG_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [SRC_W-1:0] shutdownSrc,
    input wire logic tbBoundary,
    output logic pwmShutdown_r,
    output logic gatePending_r
);
    import psg_pkg::*;

    logic regWrEn;
    logic [PSG_ADDR_W-1:0] regWrAddr;
    logic [31:0] regWrData;
    logic [3:0] regWrStrb;
    logic regWrHit;
    logic [31:0] regRdData;
    logic regRdHit;
    logic [15:0] ctrl_r;
    logic [15:0] ctrlWr;
    logic [SRC_W-1:0] srcSync;
    logic [SRC_W-1:0] srcEn;
    logic autoRestart;
    logic syncMode;
    logic swForce;
    logic reqNow;
    logic clrShut;
    psg_state_t state_r;
    psg_state_t state_nxt;

    // every check runs on clk and sleeps during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // register bus front end
    psg_axil_slave u_bus (
        .clk(clk),
        .nrst(nrst),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .regWrEn(regWrEn),
        .regWrAddr(regWrAddr),
        .regWrData(regWrData),
        .regWrStrb(regWrStrb),
        .regWrHit(regWrHit),
        .regRdData(regRdData),
        .regRdHit(regRdHit)
    );

    // sources come from other clock regions, so resync them
    psg_sync #(
        .WIDTH(SRC_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .asyncIn(shutdownSrc),
        .syncOut(srcSync)
    );

    // address decode; unmapped words answer with an error
    assign regWrHit = (regWrAddr == PSG_CTRL_OFS) ||
                      (regWrAddr == PSG_STAT_OFS);
    assign regRdHit = (s_axi_araddr == PSG_CTRL_OFS) ||
                      (s_axi_araddr == PSG_STAT_OFS);

    // control fields
    assign autoRestart = ctrl_r[PSG_AUTO_RESTART_BIT];
    assign syncMode = ctrl_r[PSG_SYNC_MODE_BIT];
    assign swForce = ctrl_r[PSG_SW_FORCE_BIT];
    assign srcEn = ctrl_r[PSG_SRC_LSB +: SRC_W];

    // byte-lane merge; unimplemented bits stay zero
    always_comb begin
        ctrlWr = ctrl_r;
        if (regWrStrb[0]) begin
            ctrlWr[7:0] = regWrData[7:0];
        end
        if (regWrStrb[1]) begin
            ctrlWr[15:8] = regWrData[15:8];
        end
        ctrlWr = ctrlWr & PSG_CTRL_MASK;
    end

    // control register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= PSG_CTRL_RST;
        end else if (regWrEn && regWrAddr == PSG_CTRL_OFS) begin
            ctrl_r <= ctrlWr;
        end
    end

    // writing 1 to the shutdown status bit asks for a restart
    assign clrShut = regWrEn && (regWrAddr == PSG_STAT_OFS) &&
                     regWrStrb[0] && regWrData[PSG_ST_SHUT_BIT];

    // masked sources plus software force form one request
    assign reqNow = (|(srcSync & srcEn)) || swForce;

    // read mux
    always_comb begin
        regRdData = 32'h00000000;
        if (s_axi_araddr == PSG_CTRL_OFS) begin
            regRdData[15:0] = ctrl_r;
        end else begin
            regRdData[PSG_ST_SHUT_BIT] = pwmShutdown_r;
            regRdData[PSG_ST_PEND_BIT] = gatePending_r;
            regRdData[PSG_ST_REQ_BIT] = reqNow;
            regRdData[PSG_ST_SRC_LSB +: SRC_W] = srcSync;
        end
    end

    // shutdown sequencing; a live request beats a software clear
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PSG_RUN: begin
                if (reqNow && syncMode) begin
                    state_nxt = PSG_PEND;
                end else if (reqNow) begin
                    state_nxt = PSG_SHUT;
                end
            end
            PSG_PEND: begin
                // request is latched; a boundary is what commits it
                if (tbBoundary) begin
                    state_nxt = PSG_SHUT;
                end
            end
            PSG_SHUT: begin
                if (autoRestart && !reqNow && tbBoundary) begin
                    state_nxt = PSG_RUN;
                end else if (!autoRestart && clrShut && !reqNow) begin
                    state_nxt = PSG_RUN;
                end
            end
            default: begin
                state_nxt = PSG_RUN;
            end
        endcase
    end

    // state flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= PSG_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs registered from the next state, so they track state_r
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwmShutdown_r <= 1'b0;
            gatePending_r <= 1'b0;
        end else begin
            pwmShutdown_r <= (state_nxt == PSG_SHUT);
            gatePending_r <= (state_nxt == PSG_PEND);
        end
    end

    // checks on the sequencing

    sequence s_gatedRequest;
        (state_r == PSG_RUN) && reqNow && syncMode ##1 gatePending_r;
    endsequence

    sequence s_boundaryHit;
        gatePending_r && tbBoundary;
    endsequence

    property p_gatedWait;
        (state_r == PSG_RUN) && reqNow && syncMode |=> !pwmShutdown_r;
    endproperty
    a_gatedWait: assert property (p_gatedWait)
        else $error("gated request shut down before a boundary");

    property p_gatedCommit;
        s_gatedRequest ##0 s_boundaryHit |=> pwmShutdown_r;
    endproperty
    a_gatedCommit: assert property (p_gatedCommit)
        else $error("gated request not applied at the boundary");

    property p_pendHold;
        gatePending_r && !tbBoundary |=> gatePending_r && !pwmShutdown_r;
    endproperty
    a_pendHold: assert property (p_pendHold)
        else $error("pending shutdown left without a boundary");

    property p_immediate;
        (state_r == PSG_RUN) && |(srcSync & srcEn) && !syncMode
            |=> pwmShutdown_r;
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("immediate shutdown not applied next cycle");

    property p_forceActs;
        (state_r == PSG_RUN) && swForce
            |=> (pwmShutdown_r || gatePending_r);
    endproperty
    a_forceActs: assert property (p_forceActs)
        else $error("software force caused no shutdown event");

    property p_srcEnabled;
        (state_r == PSG_RUN) && !syncMode && !shutdownSrc[0] ##1
        (shutdownSrc[0] && srcEn[0] && !swForce)[*3]
            |-> ##[0:1] pwmShutdown_r;
    endproperty
    a_srcEnabled: assert property (p_srcEnabled)
        else $error("enabled source did not reach shutdown");

    property p_srcMasked;
        (state_r == PSG_RUN) && !swForce && ((srcSync & srcEn) == '0)
            |=> !pwmShutdown_r && !gatePending_r;
    endproperty
    a_srcMasked: assert property (p_srcMasked)
        else $error("disabled source caused a shutdown");

    property p_manualHold;
        pwmShutdown_r && !autoRestart && !clrShut |=> pwmShutdown_r;
    endproperty
    a_manualHold: assert property (p_manualHold)
        else $error("shutdown released without a software clear");

    property p_autoResume;
        pwmShutdown_r && autoRestart && !reqNow && tbBoundary
            |=> !pwmShutdown_r;
    endproperty
    a_autoResume: assert property (p_autoResume)
        else $error("auto restart did not resume at the boundary");

    property p_clearRelease;
        pwmShutdown_r && !autoRestart && clrShut && !reqNow
            |=> !pwmShutdown_r;
    endproperty
    a_clearRelease: assert property (p_clearRelease)
        else $error("software clear did not release the shutdown");

    // a clear racing a live request must lose
    property p_setWins;
        pwmShutdown_r && clrShut && reqNow |=> pwmShutdown_r;
    endproperty
    a_setWins: assert property (p_setWins)
        else $error("clear released a shutdown with a live request");

    property p_forceNow;
        (state_r == PSG_RUN) && swForce && !syncMode |=> pwmShutdown_r;
    endproperty
    a_forceNow: assert property (p_forceNow)
        else $error("immediate software force not applied next cycle");

    // auto restart only ever leaves shutdown on a boundary
    property p_autoWait;
        pwmShutdown_r && autoRestart && !tbBoundary |=> pwmShutdown_r;
    endproperty
    a_autoWait: assert property (p_autoWait)
        else $error("auto restart resumed away from a boundary");
endmodule : psg_shutdown_gate_control
`default_nettype wire

// File: psg_shutdown_gate_control_tb.sv
// Purpose: self-checking bench for the shutdown/gate control block
// Assumes: register answers come back over the bus handshake
// Notes: clear writes go to the status word; strobes narrowed for two writes
`timescale 1ns/1ns
`default_nettype none
module psg_shutdown_gate_control_tb;
    import psg_pkg::*;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [7:0] fireMask = 8'h00;
    logic boundaryReq = 1'h0;
    logic [3:0] wstrb = 4'hF;
    logic req;
    logic awready, wready, bvalid, arready, rvalid, pwm, pend, tbB;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] src, en, sv;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    integer seed = 32'hA2B7;

    always #5 clk = ~clk;

    psg_shutdown_gate_control u_dut (
        .clk(clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .shutdownSrc(src),
        .tbBoundary(tbB), .pwmShutdown_r(pwm), .gatePending_r(pend)
    );

    psg_src_model u_src (
        .clk(clk), .nrst(nrst), .fireMask(fireMask),
        .boundaryReq(boundaryReq), .shutdownSrc(src), .tbBoundary(tbB)
    );

    // expected shutdown request from enables, sources and force
    function automatic logic expShut(input logic [7:0] e, input logic [7:0] s,
                                     input logic f);
        return (|(e & s)) | f;
    endfunction : expShut

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic cb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : cb

    task automatic results;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // no cycle count assumed; the response handshake ends this wait, the hang guard a stuck one
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!(bvalid && bready));
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, r});
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!(rvalid && rready));
        rready <= 1'h0;
        chk(rdata, d);
        chk({30'h0, rresp}, {30'h0, r});
    endtask : rd

    task automatic fire(input logic [7:0] m);
        @(posedge clk);
        fireMask <= m;
    endtask : fire

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitc

    task automatic boundary;
        @(posedge clk);
        boundaryReq <= 1'h1;
        @(posedge clk);
        boundaryReq <= 1'h0;
    endtask : boundary

    // software clear once sources are quiet
    task automatic clr;
        fire(8'h00);
        waitc(4);
        wr(PSG_STAT_OFS, 32'h1, PSG_RESP_OKAY);
        cb(pwm, 1'h0);
    endtask : clr

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            results;
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        rd(PSG_CTRL_OFS, 32'h0, PSG_RESP_OKAY);
        rd(PSG_STAT_OFS, 32'h0, PSG_RESP_OKAY);
        // unimplemented and upper bits stay zero
        wr(PSG_CTRL_OFS, 32'hFFFF2F00, PSG_RESP_OKAY);
        rd(PSG_CTRL_OFS, 32'h0, PSG_RESP_OKAY);
        wr(PSG_CTRL_OFS, 32'hFFFFC0FF, PSG_RESP_OKAY);
        rd(PSG_CTRL_OFS, 32'h0000C0FF, PSG_RESP_OKAY);
        wr(8'h10, 32'h1, PSG_RESP_SLVERR);
        rd(8'h10, 32'h0, PSG_RESP_SLVERR);
        // narrow strobes leave the other byte lane alone
        wstrb <= 4'h1;
        wr(PSG_CTRL_OFS, 32'h000010AA, PSG_RESP_OKAY);
        rd(PSG_CTRL_OFS, 32'h0000C0AA, PSG_RESP_OKAY);
        wstrb <= 4'h2;
        wr(PSG_CTRL_OFS, 32'h000000FF, PSG_RESP_OKAY);
        rd(PSG_CTRL_OFS, 32'h000000AA, PSG_RESP_OKAY);
        wstrb <= 4'hF;
        // each source alone, immediate mode, no auto restart
        for (int k = 0; k < 8; k++) begin
            wr(PSG_CTRL_OFS, 32'h1 << k, PSG_RESP_OKAY);
            fire(8'h01 << k);
            waitc(2);
            cb(pwm, 1'h0);
            waitc(1);
            cb(pwm, 1'h1);
            // clear while the source is still live: set wins
            wr(PSG_STAT_OFS, 32'h1, PSG_RESP_OKAY);
            cb(pwm, 1'h1);
            fire(8'h00);
            waitc(4);
            boundary;
            waitc(2);
            cb(pwm, 1'h1);
            rd(PSG_STAT_OFS, 32'h1, PSG_RESP_OKAY);
            clr;
        end
        // random enables against random sources
        repeat (12) begin
            en = 8'($random(seed));
            sv = 8'($random(seed));
            wr(PSG_CTRL_OFS, {24'h0, en}, PSG_RESP_OKAY);
            fire(sv);
            waitc(5);
            cb(pwm, expShut(en, sv, 1'h0));
            req = expShut(en, sv, 1'h0);
            rd(PSG_STAT_OFS, {16'h0, sv, 5'h0, req, 1'h0, req},
               PSG_RESP_OKAY);
            clr;
        end
        // software force, immediate
        wr(PSG_CTRL_OFS, 32'h00001000, PSG_RESP_OKAY);
        cb(pwm, expShut(8'h00, 8'h00, 1'h1));
        wr(PSG_CTRL_OFS, 32'h0, PSG_RESP_OKAY);
        clr;
        // gated source, dropped before the boundary
        wr(PSG_CTRL_OFS, 32'h00004004, PSG_RESP_OKAY);
        fire(8'h04);
        waitc(5);
        cb(pend, 1'h1);
        cb(pwm, 1'h0);
        fire(8'h00);
        waitc(4);
        cb(pwm, 1'h0);
        boundary;
        waitc(2);
        cb(pwm, 1'h1);
        cb(pend, 1'h0);
        clr;
        // gated software force
        wr(PSG_CTRL_OFS, 32'h00005000, PSG_RESP_OKAY);
        waitc(2);
        cb(pend, 1'h1);
        cb(pwm, 1'h0);
        wr(PSG_CTRL_OFS, 32'h0, PSG_RESP_OKAY);
        boundary;
        waitc(2);
        cb(pwm, 1'h1);
        clr;
        // auto restart resumes at a boundary; clear write has no effect
        wr(PSG_CTRL_OFS, 32'h00008002, PSG_RESP_OKAY);
        fire(8'h02);
        waitc(5);
        cb(pwm, 1'h1);
        fire(8'h00);
        waitc(4);
        wr(PSG_STAT_OFS, 32'h1, PSG_RESP_OKAY);
        cb(pwm, 1'h1);
        boundary;
        waitc(2);
        cb(pwm, 1'h0);
        results;
    end
endmodule : psg_shutdown_gate_control_tb
`default_nettype wire

// File: psg_src_model.sv
// Purpose: far-side model of the shutdown sources and the time base
// Assumes: sources are levels that settle a little after each command
// Notes: skew keeps source edges away from the sampling clock edge
`timescale 1ns/1ns
`default_nettype none
module psg_src_model #(
    parameter int SKEW = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] fireMask,
    input wire logic boundaryReq,
    output logic [7:0] shutdownSrc,
    output var logic tbBoundary
);
    // comparator and logic-cell outputs, asynchronous to clk
    // continuous so the sources idle low from SKEW after time zero, never unknown after that
    assign #(SKEW) shutdownSrc = fireMask;

    // time-base reset or rollover, one cycle long per request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tbBoundary <= 1'h0;
        end else begin
            tbBoundary <= boundaryReq && !tbBoundary;
        end
    end
endmodule : psg_src_model
`default_nettype wire

// File: psg_sync.sv
// Purpose: two-flop synchroniser for the shutdown sources
// Assumes: sources are asynchronous levels
// Notes: only the last stage may be read by logic
`timescale 1ns/1ns
`default_nettype none
module psg_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import psg_pkg::*;

    // one chain per source bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            logic stable_r;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r <= asyncIn[i];
                    stable_r <= meta_r; // meta_r feeds nothing else
                end
            end
            assign syncOut[i] = stable_r;
        end
    endgenerate
endmodule : psg_sync
`default_nettype wire
